// File: design/bis_defs.svh
`ifndef BIS_DEFS_SVH
`define BIS_DEFS_SVH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define BIS_ADDR_INSTR   8'h00
`define BIS_ADDR_ACC     8'h04
`define BIS_ADDR_FLAGS   8'h08
`define BIS_ADDR_LATCH   8'h0c
`define BIS_ADDR_PC      8'h10
`define BIS_ADDR_FILE    8'h14
`define BIS_ADDR_STATUS  8'h18
// ----------------------------------------
// instruction word layout (14-bit)
// ----------------------------------------
`define BIS_OP_HI        13
`define BIS_OP_LO        8
`define BIS_DEST_BIT     7
`define BIS_IDX_HI       6
`define BIS_JMP_HI       10
`define BIS_JMP_OP       3'h5
`define BIS_OPC_ORLIT    6'h38
`define BIS_OPC_INC      6'h0a
`define BIS_OPC_ORFILE   6'h04
`define BIS_OPC_LSL      6'h35
`define BIS_OPC_LSR      6'h36
// ----------------------------------------
// flag bits, reset values and increment constants
// ----------------------------------------
`define BIS_FLAG_C       0
`define BIS_FLAG_Z       2
`define BIS_RST_BYTE     8'h00
`define BIS_RST_PC       15'h0000
`define BIS_RST_WORD     32'h0000_0000
`define BIS_ONE_BYTE     8'h01
`define BIS_PC_STEP      15'h0001
`define BIS_RST_LATCH    7'h00
`define BIS_RST_INSTR    14'h0000
`endif

// File: design/bis_pkg.sv
package bis_pkg;
  // execution states, one-hot
  typedef enum logic [2:0] {
    BIS_IDLE  = 3'b001,
    BIS_JMP2  = 3'b010,
    BIS_DONE  = 3'b100
  } bis_state_t;
endpackage

// File: design/bis_exec.sv
`timescale 1ns/10ps
// Contract
// - jump loads 11-bit immediate into pc low
// - jump fills pc upper from latch bits
// - jump takes two cycles, flags unchanged
// - literal or into accumulator, zero updated
// - destination bit selects accumulator or file
// - increment file value, only zero updated
// - or accumulator with file, zero updated
// - left shift, bit7 to carry, zero in
// - right shift, bit0 to carry, zero in

// ----------------------------------------
// overview
// ----------------------------------------
// software feeds one instruction word per bus write
// to the instruction offset; the word is decoded in
// the data phase of that write and executed at the
// edge that closes it
// - single-cycle ops update accumulator, file bank,
//   flags and program counter at that one edge
// - a jump is captured at that edge and the counter
//   is loaded one edge later, so it spans two cycles
// - the state offset reads back the one-hot executor
//   state, so software can see a jump in flight
//
// register map, one aligned word each
// - instruction, write only, low 14 bits used
// - accumulator, low byte
// - flags, carry in bit 0, zero in bit 2
// - upper jump latch, 7 bits
// - program counter, 15 bits
// - file window, index taken from address bits 14:8
// - executor state, one-hot
// unmapped offsets read zero and ignore writes
//
// bus timing
// - zero wait states: ready is always high
// - read data is captured at the address phase edge,
//   so a read sees every write completed before it
// - response is always okay
//
// hazards and limits
// - a second jump while one is in flight is dropped;
//   software waits two cycles after a jump
// - other ops during a jump still run, but the jump
//   load wins the counter at its second edge
// - clock enable low freezes every register, the
//   file bank and the bus phase tracking alike
// - the file bank has no reset: it holds garbage
//   until software loads it, as real ram would
// - the two sources for the upper jump bits disagree;
//   latch bits 6:3 were taken, which uses the whole
//   upper field of the counter
`include "bis_defs.svh"
module bis_exec
  import bis_pkg::*;
(
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  // ----------------------------------------
  // file register bank, kept local for test access
  // ----------------------------------------
  logic [7:0]  file_mem [0:127];            // 128 file registers
  logic [7:0]  acc_reg;                     // accumulator
  logic [7:0]  acc_next;                    // accumulator next
  logic        carry_reg;                   // bit shifted out flag
  logic        carry_next;                  // carry next
  logic        zero_reg;                    // result null flag
  logic        zero_next;                   // zero next
  logic [6:0]  latch_reg;                   // upper jump latch
  logic [14:0] pc_reg;                      // program counter
  logic [14:0] pc_next;                     // pc next
  logic [13:0] instr_reg;                   // instruction held for jump
  bis_state_t  state_reg;                   // executor state
  bis_state_t  state_next;                  // state next
  logic [31:0] hrdata_reg;                  // read data register
  logic        hresp_reg;                   // always okay
  logic        hreadyout_reg;               // always ready, held in a flop
  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  logic        ap_valid_reg;                // data phase pending
  logic        ap_write_reg;                // pending is a write
  logic [7:0]  ap_addr_reg;                 // pending byte address
  logic [6:0]  ap_fidx_reg;                 // pending file index
  wire         ap_take   = hsel & htrans[1] & hready;
  wire         ph_wr     = ap_valid_reg & ap_write_reg;
  wire         ph_rd     = ap_valid_reg & ~ap_write_reg;
  // write decode in data phase
  wire         wr_instr  = ph_wr & (ap_addr_reg == `BIS_ADDR_INSTR);
  wire         wr_acc    = ph_wr & (ap_addr_reg == `BIS_ADDR_ACC);
  wire         wr_flags  = ph_wr & (ap_addr_reg == `BIS_ADDR_FLAGS);
  wire         wr_latch  = ph_wr & (ap_addr_reg == `BIS_ADDR_LATCH);
  wire         wr_pc     = ph_wr & (ap_addr_reg == `BIS_ADDR_PC);
  wire         wr_file   = ph_wr & (ap_addr_reg[7:0] >= `BIS_ADDR_FILE)
                           & (ap_addr_reg < `BIS_ADDR_STATUS);
  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  wire [13:0]  ins       = hwdata[13:0];
  wire [5:0]   opc       = ins[`BIS_OP_HI:`BIS_OP_LO];
  wire [6:0]   fidx      = ins[`BIS_IDX_HI:0];
  wire         dest_file = ins[`BIS_DEST_BIT];
  wire [7:0]   lit       = ins[7:0];
  wire [7:0]   fval      = file_mem[fidx];
  wire         is_jmp    = wr_instr & (ins[13:11] == `BIS_JMP_OP) & (state_reg == BIS_IDLE);
  // opcode strobes, each valid only in an instruction data phase
  wire         is_orlit  = wr_instr & (opc == `BIS_OPC_ORLIT);
  wire         is_inc    = wr_instr & (opc == `BIS_OPC_INC);
  wire         is_orfile = wr_instr & (opc == `BIS_OPC_ORFILE);
  wire         is_lsl    = wr_instr & (opc == `BIS_OPC_LSL);
  wire         is_lsr    = wr_instr & (opc == `BIS_OPC_LSR);
  // any op that reads the file bank and may write it back
  wire         is_fop    = is_inc | is_orfile | is_lsl | is_lsr;
  // ----------------------------------------
  // alu results
  // ----------------------------------------
  // all results computed in parallel, selected below;
  // cheaper than a shared adder at this width
  wire [7:0]   res_inc   = fval + `BIS_ONE_BYTE;
  wire [7:0]   res_orfile = acc_reg | fval;
  wire [7:0]   res_lsl   = {fval[6:0], 1'b0};
  wire [7:0]   res_lsr   = {1'b0, fval[7:1]};
  wire [7:0]   res_orlit = acc_reg | lit;
  // file-op result, lsr is the fall-through
  wire [7:0]   res_f     = is_inc    ? res_inc    :
                           is_orfile ? res_orfile :
                           is_lsl    ? res_lsl    : res_lsr;
  // result of whichever op runs this cycle
  wire [7:0]   res_any   = is_orlit ? res_orlit : res_f;
  wire         res_zero  = (res_any == `BIS_RST_BYTE);
  // jump target: upper bits from latch, conflicting sources resolved to 6:3
  wire [14:0]  jmp_pc    = {latch_reg[6:3], instr_reg[`BIS_JMP_HI:0]};
  // ----------------------------------------
  // next-state and datapath selection
  // ----------------------------------------
  always_comb
  begin
    acc_next   = acc_reg;
    carry_next = carry_reg;
    zero_next  = zero_reg;
    pc_next    = pc_reg;
    state_next = state_reg;
    // software writes
    if (wr_acc)
      acc_next = hwdata[7:0];
    if (wr_flags)
    begin
      carry_next = hwdata[`BIS_FLAG_C];
      zero_next  = hwdata[`BIS_FLAG_Z];
    end
    if (wr_pc)
      pc_next = hwdata[14:0];
    // single-cycle ops; a software write and an op never share
    // one data phase, so no priority question arises here
    // accumulator target: literal op always, file ops when dest is 0
    if (is_orlit | (is_fop & ~dest_file))
      acc_next = res_any;
    // every op here touches the zero flag
    if (is_orlit | is_fop)
      zero_next = res_zero;
    // only the shifts touch carry
    if (is_lsl)
      carry_next = fval[7];
    if (is_lsr)
      carry_next = fval[0];
    // sequential flow for every non-jump op
    if (is_orlit | is_fop)
      pc_next = pc_reg + `BIS_PC_STEP;
    // jump sequence, no flag touched
    unique case (state_reg)
      BIS_IDLE:
        if (is_jmp)
          state_next = BIS_JMP2;
      BIS_JMP2:
      begin
        pc_next    = jmp_pc;
        state_next = BIS_DONE;
      end
      BIS_DONE:
        state_next = BIS_IDLE;
      default:
        state_next = BIS_IDLE;
    endcase
  end
  // ----------------------------------------
  // bus phase registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= `BIS_RST_BYTE;
      ap_fidx_reg  <= `BIS_RST_LATCH;
    end
    else if (clk_en & hready)
    begin
      ap_valid_reg <= ap_take;
      ap_write_reg <= hwrite;
      ap_addr_reg  <= haddr[7:0];
      ap_fidx_reg  <= haddr[14:8];
    end
  end
  // ----------------------------------------
  // core state
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_reg   <= `BIS_RST_BYTE;
      carry_reg <= 1'b0;
      zero_reg  <= 1'b0;
      pc_reg    <= `BIS_RST_PC;
      latch_reg <= `BIS_RST_LATCH;
      instr_reg <= `BIS_RST_INSTR;
      state_reg <= BIS_IDLE;
    end
    else if (clk_en)
    begin
      acc_reg   <= acc_next;
      carry_reg <= carry_next;
      zero_reg  <= zero_next;
      pc_reg    <= pc_next;
      state_reg <= state_next;
      if (wr_latch)
        latch_reg <= hwdata[6:0];
      if (is_jmp)
        instr_reg <= ins;
    end
  end
  // ----------------------------------------
  // file bank: result write-back or direct load
  // ----------------------------------------
  always_ff @(posedge hclk)
  begin
    if (clk_en & is_fop & dest_file)
      file_mem[fidx] <= res_f;
    else if (clk_en & wr_file)
      file_mem[ap_fidx_reg] <= hwdata[7:0];
  end
  // ----------------------------------------
  // read mux, captured at the address phase
  // ----------------------------------------
  // capturing early keeps read data in a flop and still
  // sees every write that finished before this read
  wire [7:0]  ra       = haddr[7:0];
  wire [31:0] rd_mux   =
    (ra == `BIS_ADDR_ACC)    ? {24'h000000, acc_reg} :
    (ra == `BIS_ADDR_FLAGS)  ? {29'h00000000, zero_reg, 1'b0, carry_reg} :
    (ra == `BIS_ADDR_LATCH)  ? {25'h0000000, latch_reg} :
    (ra == `BIS_ADDR_PC)     ? {17'h00000, pc_reg} :
    (ra == `BIS_ADDR_FILE)   ? {24'h000000, file_mem[haddr[14:8]]} :
    (ra == `BIS_ADDR_STATUS) ? {29'h00000000, state_reg} : `BIS_RST_WORD;
  // read data and response flops, outputs come straight from here
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_reg    <= `BIS_RST_WORD;
      hresp_reg     <= 1'b0;
      hreadyout_reg <= 1'b1;
    end
    else if (clk_en & ap_take & ~hwrite)
      hrdata_reg <= rd_mux;
  end
  // outputs, all registered
  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
endmodule // bis_exec

// File: verif/bis_prog_rom.sv
`timescale 1ns/10ps
module bis_prog_rom
(
  // word select
  input  wire logic [3:0]  idx,
  // instruction word
  output logic      [13:0] word
);
  // fixed program, combinational so a word is ready before its data phase
  always_comb
  begin
    case (idx)
      4'h0:    word = 14'h357f; // shift left of file 7f into acc
      4'h1:    word = 14'h2da5; // jump to 5a5
      4'h2:    word = 14'h3800; // or literal 00
      4'h3:    word = 14'h3881; // or literal 81
      4'h4:    word = 14'h0a85; // increment file 05 in place
      4'h5:    word = 14'h0a05; // increment file 05 into acc
      4'h6:    word = 14'h04c0; // or acc into file 40
      4'h7:    word = 14'h36c0; // shift right file 40 in place
      4'h8:    word = 14'h3640; // shift right file 40 into acc
      4'h9:    word = 14'h35c0; // shift left file 40 in place
      default: word = 14'h0000; // unused slots
    endcase
  end
endmodule // bis_prog_rom

// File: verif/bis_exec_assertions.sv
`timescale 1ns/10ps
`include "bis_defs.svh"
module bis_exec_checker
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  // bus signals
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  logic [7:0] rd_a; // offset read in this data phase, ff when none
  // -------------------------------------
  // read tracking
  // -------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_a <= 8'hff;
    else if (hready)
      rd_a <= (hsel && htrans[1] && !hwrite && clk_en) ? haddr[7:0] : 8'hff;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_acc_byte: assert property (rd_a == `BIS_ADDR_ACC |-> hrdata[31:8] == 24'h0)
    else $error("acc read wider than a byte");
  chk_file_byte: assert property (rd_a == `BIS_ADDR_FILE |-> hrdata[31:8] == 24'h0)
    else $error("file read wider than a byte");
  chk_flag_bits: assert property (rd_a == `BIS_ADDR_FLAGS |-> hrdata[31:3] == 29'h0 && !hrdata[1])
    else $error("flag read has stray bits");
  chk_pc_width: assert property (rd_a == `BIS_ADDR_PC |-> hrdata[31:15] == 17'h0)
    else $error("pc read wider than 15 bits");
  chk_state_hot: assert property (rd_a == `BIS_ADDR_STATUS |-> $onehot(hrdata[2:0]))
    else $error("state not one-hot");
  chk_unmapped_zero: assert property (rd_a inside {[8'h1c:8'hfe]} |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_zero_wait: assert property (hsel && htrans[1] |-> !hresp ##1 hreadyout && !hresp)
    else $error("transfer stalled or errored");
  chk_data_holds: assert property (rd_a == 8'hff |-> $stable(hrdata))
    else $error("read data moved without a read");
  cover property (rd_a == `BIS_ADDR_PC);
  cover property (rd_a == `BIS_ADDR_STATUS && hrdata[1]);
  cover property (rd_a == `BIS_ADDR_FLAGS && hrdata[2]);
endmodule // bis_exec_checker
bind bis_exec bis_exec_checker chk_i (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp);

// File: verif/branch_or_inc_shift_exec_tb.sv
`timescale 1ns/10ps
`include "bis_defs.svh"
module branch_or_inc_shift_exec_tb;
  // -------------------------------------
  // bench signals
  // -------------------------------------
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        clk_en = 1'b1; // freeze not exercised here
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic        hreadyout, hresp;
  logic [3:0]  idx = 4'h0;
  logic [13:0] word;
  int          errors = 0;
  int          compares = 0;
  int          cyc = 0;
  always #50 hclk = ~hclk;
  bis_exec uut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp);
  bis_prog_rom mem (.idx, .word);
  // single transfer; an instruction write takes its word from the rom
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= (w && a == `BIS_ADDR_INSTR) ? {18'h0, word} : d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    compares++;
    if (q !== e)
    begin
      errors++;
      $display("unexpected at %0t: read %h gave %h, want %h", $time, a, q, e);
    end
  endtask
  task automatic step(input logic [3:0] i);
    idx = i;
    bus(1'b1, `BIS_ADDR_INSTR, 32'h0);
    $display("test step %0d done", i);
  endtask
  task automatic wrap_up();
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, the sequence needs under a hundred cycles
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(`BIS_ADDR_STATUS, 32'h1);
    bus(1'b1, `BIS_ADDR_ACC, 32'h0);
    bus(1'b1, {17'h0, 7'h7f, `BIS_ADDR_FILE}, 32'h80);
    bus(1'b1, `BIS_ADDR_LATCH, 32'h58);
    step(4'h0);
    chk(`BIS_ADDR_ACC, 32'h0);
    chk(`BIS_ADDR_FLAGS, 32'h5);
    step(4'h1);
    chk(`BIS_ADDR_STATUS, 32'h2);
    chk(`BIS_ADDR_PC, 32'h5da5);
    chk(`BIS_ADDR_FLAGS, 32'h5);
    step(4'h2);
    chk(`BIS_ADDR_FLAGS, 32'h5);
    step(4'h3);
    chk(`BIS_ADDR_ACC, 32'h81);
    chk(`BIS_ADDR_FLAGS, 32'h1);
    bus(1'b1, {17'h0, 7'h05, `BIS_ADDR_FILE}, 32'hff);
    step(4'h4);
    chk({17'h0, 7'h05, `BIS_ADDR_FILE}, 32'h0);
    chk(`BIS_ADDR_ACC, 32'h81);
    chk(`BIS_ADDR_FLAGS, 32'h5);
    step(4'h5);
    chk(`BIS_ADDR_ACC, 32'h1);
    chk(`BIS_ADDR_FLAGS, 32'h1);
    bus(1'b1, {17'h0, 7'h40, `BIS_ADDR_FILE}, 32'h30);
    step(4'h6);
    chk({17'h0, 7'h40, `BIS_ADDR_FILE}, 32'h31);
    step(4'h7);
    chk({17'h0, 7'h40, `BIS_ADDR_FILE}, 32'h18);
    chk(`BIS_ADDR_FLAGS, 32'h1);
    step(4'h8);
    chk(`BIS_ADDR_ACC, 32'h0c);
    chk(`BIS_ADDR_FLAGS, 32'h0);
    step(4'h9);
    chk({17'h0, 7'h40, `BIS_ADDR_FILE}, 32'h30);
    chk(`BIS_ADDR_PC, 32'h5dad);
    chk(32'h20, 32'h0);
    wrap_up();
  end
endmodule // branch_or_inc_shift_exec_tb
